/* File: pkg/eeprom_consts.svh */
// Purpose: Shared constants for the two-wire EEPROM slave port and its master
// Assumes: Included by bare name; definitions only
// Notes:   Times are kept in ns next to the cycle counts derived from them
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH

`define MEM_DEPTH      512
`define PAGE_BYTES     16
`define SEL_FAMILY     4'hA
`define RW_READ        1'h1
`define CLK_PERIOD_NS  4
`define WRITE_TIME_NS  5000000
// Longest time, rounded down to whole cycles
`define WRITE_CYCLES   (`WRITE_TIME_NS / `CLK_PERIOD_NS)
`define SCL_PERIOD_NS  1000
// Least quarter of an SCL period, rounded up to whole cycles
`define SCL_QUARTER_CYCLES ((`SCL_PERIOD_NS + 4 * `CLK_PERIOD_NS - 1) / (4 * `CLK_PERIOD_NS))

`endif

/* File: pkg/eeprom_pkg.sv */
// Purpose: Types shared by both ends of the two-wire link
// Assumes: Constants live in eeprom_consts.svh
// Notes:   States carry no explicit codes
package eeprom_pkg;

   typedef enum logic [2:0] {
      DEV_STANDBY,
      DEV_SELECT,
      DEV_WORD,
      DEV_DATA,
      DEV_SEND,
      DEV_ACK_OUT,
      DEV_ACK_IN,
      DEV_IGNORE
   } dev_state_t;

   typedef enum logic [1:0] {
      H_IDLE,
      H_START,
      H_BITS,
      H_STOP
   } host_state_t;

   typedef enum logic [1:0] {
      HCMD_START,
      HCMD_STOP,
      HCMD_WRITE,
      HCMD_READ
   } host_cmd_t;

endpackage

/* File: pkg/two_wire_if.sv */
// Purpose: Open-drain two-wire bus joining the master and the EEPROM port
// Assumes: Enables are active low; a released line is pulled high
// Notes:   Only this interface resolves the wire levels
`timescale 1ns/1ps
interface two_wire_if;
   logic host_scl_o;
   logic host_scl_oe_n;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic scl;
   logic sda;

   // Wired-AND with pull-up on both lines
   assign scl = host_scl_oe_n | host_scl_o;
   assign sda = (dev_sda_oe_n | dev_sda_o) & (host_sda_oe_n | host_sda_o);

   modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
   modport host   (input sda, output host_scl_o, output host_scl_oe_n,
                   output host_sda_o, output host_sda_oe_n);
endinterface

/* File: verilog/two_wire_master.sv */
// Purpose: Bus master end: makes SCL and framing, sends and receives bytes
// Assumes: One command at a time, taken while READY_OUT is high
// Notes:   SCL runs at the fastest allowed rate from a quarter-period enable
`timescale 1ns/1ps
`include "eeprom_consts.svh"
module two_wire_master (
   input  wire logic                REF_CLK_IN,
   input  wire logic                RESET_N_IN,
   two_wire_if.host                 bus,
   input  wire logic                CMD_VALID_IN,
   input  wire eeprom_pkg::host_cmd_t CMD_IN,
   input  wire logic [7:0]          TX_BYTE_IN,
   input  wire logic                ACK_SEND_IN,
   output logic                     READY_OUT,
   output logic                     DONE_OUT,
   output logic [7:0]               RX_BYTE_OUT,
   output logic                     ACK_SEEN_OUT
);
   localparam logic [7:0] QUARTER = 8'(`SCL_QUARTER_CYCLES);

   eeprom_pkg::host_state_t state;
   logic [7:0] div;
   logic       tick;
   logic [1:0] phase;
   logic [3:0] bit_idx;
   logic [8:0] tx;
   logic [8:0] rx;
   logic       sda_meta;
   logic       sda_sync;
   logic       scl_low;
   logic       sda_low;

   // Quarter-period enable; restarts with each command so phases align
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESET_N_IN || state == eeprom_pkg::H_IDLE) begin
         div  <= 8'h00;
         tick <= 1'h0;
      end else begin
         tick <= (div == QUARTER - 8'h01);
         div  <= (div == QUARTER - 8'h01) ? 8'h00 : div + 8'h01;
      end
   end

   // The wire is another party's, so it is synchronised before use
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESET_N_IN) begin
         sda_meta <= 1'h1;
         sda_sync <= 1'h1;
      end else begin
         sda_meta <= bus.sda;
         sda_sync <= sda_meta;
      end
   end

   // Command sequencer; SDA only moves in phase 0 or 2 with SCL settled
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESET_N_IN) begin
         state   <= eeprom_pkg::H_IDLE;
         phase   <= 2'h0;
         bit_idx <= 4'h0;
         tx      <= 9'h1FF;
         rx      <= 9'h000;
         scl_low <= 1'h0;
         sda_low <= 1'h0;
         DONE_OUT <= 1'h0;
      end else begin
         DONE_OUT <= 1'h0;
         if (state == eeprom_pkg::H_IDLE) begin
            phase   <= 2'h0;
            bit_idx <= 4'h0;
            if (CMD_VALID_IN) begin
               case (CMD_IN)
                  eeprom_pkg::HCMD_START: state <= eeprom_pkg::H_START;
                  eeprom_pkg::HCMD_STOP:  state <= eeprom_pkg::H_STOP;
                  eeprom_pkg::HCMD_WRITE: begin
                     state <= eeprom_pkg::H_BITS;
                     tx    <= {TX_BYTE_IN, 1'h1};
                  end
                  default: begin
                     state <= eeprom_pkg::H_BITS;
                     tx    <= {8'hFF, ACK_SEND_IN};
                  end
               endcase
            end
         end else if (tick) begin
            phase <= phase + 2'h1;
            case (state)
               eeprom_pkg::H_START: begin
                  case (phase)
                     2'h0:    sda_low <= 1'h0;
                     2'h1:    scl_low <= 1'h0;
                     2'h2:    sda_low <= 1'h1;
                     default: scl_low <= 1'h1;
                  endcase
               end
               eeprom_pkg::H_BITS: begin
                  case (phase)
                     2'h0:    sda_low <= !tx[8];
                     2'h1:    scl_low <= 1'h0;
                     2'h2:    rx <= {rx[7:0], sda_sync};
                     default: begin
                        scl_low <= 1'h1;
                        tx      <= {tx[7:0], 1'h1};
                        bit_idx <= bit_idx + 4'h1;
                     end
                  endcase
               end
               eeprom_pkg::H_STOP: begin
                  case (phase)
                     2'h0:    sda_low <= 1'h1;
                     2'h1:    scl_low <= 1'h0;
                     2'h2:    sda_low <= 1'h0;
                     default: ;
                  endcase
               end
               default: ;
            endcase
            // Nine bits per byte, four phases per bit or frame edge
            if (phase == 2'h3 && (state != eeprom_pkg::H_BITS || bit_idx == 4'h8)) begin
               state    <= eeprom_pkg::H_IDLE;
               DONE_OUT <= 1'h1;
            end
         end
      end
   end

   // Drivers and results; SCL is always made here
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESET_N_IN) begin
         bus.host_scl_o    <= 1'h0;
         bus.host_sda_o    <= 1'h0;
         bus.host_scl_oe_n <= 1'h1;
         bus.host_sda_oe_n <= 1'h1;
         READY_OUT         <= 1'h0;
         RX_BYTE_OUT       <= 8'h00;
         ACK_SEEN_OUT      <= 1'h0;
      end else begin
         bus.host_scl_o    <= 1'h0;
         bus.host_sda_o    <= 1'h0;
         bus.host_scl_oe_n <= !scl_low;
         bus.host_sda_oe_n <= !sda_low;
         READY_OUT         <= (state == eeprom_pkg::H_IDLE) && !CMD_VALID_IN;
         RX_BYTE_OUT       <= rx[8:1];
         ACK_SEEN_OUT      <= !rx[0];
      end
   end
endmodule

/* File: verilog/two_wire_eeprom_slave_port.sv */
// Purpose: Slave end of a 512x8 two-wire EEPROM with 16-byte pages
// Assumes: SCL and SDA are sampled by REF_CLK_IN, well above 1 MHz SCL
// Notes:   RESET_N_IN stands in for the power-on reset indication
//
// Function
// - Store 512 bytes in 16-byte pages
// - Partial page writes program only received bytes
// - Self-timed program cycle ends within 5 ms
// - Ignore bus in reset, then enter standby
// - Stop gives standby unless programming runs
// - Write-protect high blocks every array change; here only data bytes received while it is high are refused
// - Match only two upper chip-select inputs
// - SDA only pulled low or released
// - Master alone drives SCL and framing
// - Master starts transfers only on idle bus
// - SDA steady while SCL is high
// - SDA change with SCL high is framing
// - One SCL pulse per bit, sampled high
// - Transactions open with start, close with stop
// - SDA meaningless until a start is seen
// - Bytes: select, location, then data
// - Correct operation up to 1 MHz SCL
// - Start is SDA fall, stop SDA rise
// - Acknowledge each accepted byte on ninth pulse
// - Page writes wrap the low four bits
`timescale 1ns/1ps
`include "eeprom_consts.svh"
module two_wire_eeprom_slave_port #(
   parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
   input  wire logic REF_CLK_IN,
   input  wire logic RESET_N_IN,
   two_wire_if.device bus,
   input  wire logic CHIP_SELECT_BIT0_UNUSED_IN,
   input  wire logic CHIP_SELECT_BIT1_IN,
   input  wire logic CHIP_SELECT_BIT2_IN,
   input  wire logic WRITE_PROTECT_IN,
   output logic      BUSY_OUT,
   output logic      STANDBY_OUT
);
   eeprom_pkg::dev_state_t state;
   eeprom_pkg::dev_state_t ack_next;

   logic [7:0]  mem [`MEM_DEPTH];
   logic [7:0]  page_data [`PAGE_BYTES];
   logic [15:0] page_mask;
   logic [8:4]  page_base;
   logic [8:0]  ptr;
   logic [7:0]  shift;
   logic [3:0]  bit_cnt;
   logic        sda_low;
   logic        busy;
   logic [31:0] prog_cnt;
   logic        scl_meta, scl_sync, scl_prev;
   logic        sda_meta, sda_sync, sda_prev;
   logic [2:0]  pin_meta, pin_sync;
   logic        scl_rise, scl_fall, start_seen, stop_seen;
   logic        store_byte, sel_match;

   // Two-stage synchronisers; only the second stage feeds logic
   // Sampling at 250 MHz leaves dozens of samples per phase of a 1 MHz SCL
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESET_N_IN) begin
         scl_meta <= 1'h1;
         scl_sync <= 1'h1;
         scl_prev <= 1'h1;
         sda_meta <= 1'h1;
         sda_sync <= 1'h1;
         sda_prev <= 1'h1;
         pin_meta <= 3'h0;
         pin_sync <= 3'h0;
      end else begin
         scl_meta <= bus.scl;
         scl_sync <= scl_meta;
         scl_prev <= scl_sync;
         sda_meta <= bus.sda;
         sda_sync <= sda_meta;
         sda_prev <= sda_sync;
         pin_meta <= {WRITE_PROTECT_IN, CHIP_SELECT_BIT2_IN, CHIP_SELECT_BIT1_IN};
         pin_sync <= pin_meta;
      end
   end

   // Edges from synchronised values; SDA moving under high SCL is framing
   assign scl_rise   = scl_sync && !scl_prev;
   assign scl_fall   = !scl_sync && scl_prev;
   assign start_seen = scl_sync && scl_prev && !sda_sync && sda_prev;
   assign stop_seen  = scl_sync && scl_prev && sda_sync && !sda_prev;

   // Family nibble, then the two wired select bits; bit 0 of the pins is unused
   assign sel_match = (shift[7:4] == `SEL_FAMILY) && (shift[3] == pin_sync[1])
                      && (shift[2] == pin_sync[0]) && !busy;
   // Data bytes are dropped, and not acknowledged, under write protect
   assign store_byte = (state == eeprom_pkg::DEV_DATA) && scl_fall && (bit_cnt == 4'h8)
                       && !pin_sync[2] && !start_seen && !stop_seen;

   // Protocol engine; reset or stop parks it in standby
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESET_N_IN) begin
         state    <= eeprom_pkg::DEV_STANDBY;
         ack_next <= eeprom_pkg::DEV_IGNORE;
         ptr      <= 9'h000;
         shift    <= 8'h00;
         bit_cnt  <= 4'h0;
         sda_low  <= 1'h0;
      end else if (start_seen) begin
         state   <= eeprom_pkg::DEV_SELECT;
         bit_cnt <= 4'h0;
         sda_low <= 1'h0;
      end else if (stop_seen) begin
         state   <= eeprom_pkg::DEV_STANDBY;
         sda_low <= 1'h0;
      end else begin
         case (state)
            eeprom_pkg::DEV_SELECT, eeprom_pkg::DEV_WORD, eeprom_pkg::DEV_DATA: begin
               if (scl_rise && bit_cnt != 4'h8) begin
                  shift   <= {shift[6:0], sda_sync};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  state <= eeprom_pkg::DEV_ACK_OUT;
                  case (state)
                     eeprom_pkg::DEV_SELECT: begin
                        sda_low  <= sel_match;
                        ptr[8]   <= sel_match ? shift[1] : ptr[8]; // Others' traffic keeps it
                        ack_next <= (shift[0] == `RW_READ) ? eeprom_pkg::DEV_SEND
                                                            : eeprom_pkg::DEV_WORD;
                        if (!sel_match) begin
                           state <= eeprom_pkg::DEV_IGNORE;
                        end
                     end
                     eeprom_pkg::DEV_WORD: begin
                        sda_low  <= 1'h1;
                        ptr[7:0] <= shift;
                        ack_next <= eeprom_pkg::DEV_DATA;
                     end
                     default: begin
                        sda_low  <= store_byte;
                        ptr[3:0] <= ptr[3:0] + 4'h1;
                        ack_next <= eeprom_pkg::DEV_DATA;
                        if (!store_byte) begin
                           state <= eeprom_pkg::DEV_IGNORE;
                        end
                     end
                  endcase
               end
            end
            eeprom_pkg::DEV_ACK_OUT: begin
               if (scl_fall) begin
                  state   <= ack_next;
                  bit_cnt <= 4'h0;
                  sda_low <= 1'h0;
                  if (ack_next == eeprom_pkg::DEV_SEND) begin
                     // First bit goes out at once; the rest on later falls
                     sda_low <= !mem[ptr][7];
                     shift   <= {mem[ptr][6:0], 1'h0};
                     bit_cnt <= 4'h1;
                  end
               end
            end
            eeprom_pkg::DEV_SEND: begin
               if (scl_fall) begin
                  if (bit_cnt == 4'h8) begin
                     sda_low <= 1'h0;
                     state   <= eeprom_pkg::DEV_ACK_IN;
                  end else begin
                     sda_low <= !shift[7];
                     shift   <= {shift[6:0], 1'h0};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            eeprom_pkg::DEV_ACK_IN: begin
               if (scl_rise) begin
                  ptr      <= ptr + 9'h001; // Whole array rolls over on reads
                  ack_next <= eeprom_pkg::DEV_SEND;
                  state    <= sda_sync ? eeprom_pkg::DEV_IGNORE : eeprom_pkg::DEV_ACK_OUT;
               end
            end
            eeprom_pkg::DEV_STANDBY, eeprom_pkg::DEV_IGNORE: ;
            default: state <= eeprom_pkg::DEV_STANDBY;
         endcase
      end
   end

   // Page buffer and self-timed program cycle; stop launches the cycle
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESET_N_IN) begin
         page_mask <= 16'h0000;
         page_base <= 5'h00;
         busy      <= 1'h0;
         prog_cnt  <= 32'h0000_0000;
      end else begin
         if (state == eeprom_pkg::DEV_WORD && scl_fall && bit_cnt == 4'h8) begin
            page_base <= {ptr[8], shift[7:4]};
         end
         if (store_byte) begin
            page_data[ptr[3:0]] <= shift;
            page_mask[ptr[3:0]] <= 1'h1;
         end
         if (stop_seen && !busy && page_mask != 16'h0000) begin
            busy     <= 1'h1;
            prog_cnt <= 32'h0000_0000;
         end else if (busy) begin
            prog_cnt <= prog_cnt + 32'h0000_0001;
            if (prog_cnt == 32'(WRITE_CYCLES - 1)) begin
               busy      <= 1'h0;
               page_mask <= 16'h0000;
            end
         end
      end
   end

   // Commit one buffered byte per cycle early in the program cycle
   always_ff @(posedge REF_CLK_IN) begin
      if (busy && prog_cnt < 32'(`PAGE_BYTES) && page_mask[prog_cnt[3:0]]) begin
         mem[{page_base, prog_cnt[3:0]}] <= page_data[prog_cnt[3:0]];
      end
   end

   // SDA is open drain: the data pin is held at zero, only the enable moves
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESET_N_IN) begin
         bus.dev_sda_o    <= 1'h0;
         bus.dev_sda_oe_n <= 1'h1;
         BUSY_OUT         <= 1'h0;
         STANDBY_OUT      <= 1'h0;
      end else begin
         bus.dev_sda_o    <= 1'h0;
         bus.dev_sda_oe_n <= !sda_low;
         BUSY_OUT         <= busy;
         STANDBY_OUT      <= (state == eeprom_pkg::DEV_STANDBY) && !busy;
      end
   end
endmodule

/* File: testbench/two_wire_eeprom_slave_port_asserts.sv */
// Purpose: Concurrent checks on the two-wire link and the port status outputs
// Assumes: One clock domain; RESET_N_IN is synchronous and active low
// Notes:   Master-side timing is checked here too, since both ends are design code
`timescale 1ns/1ps
module two_wire_eeprom_slave_port_asserts #(
   parameter int WRITE_CYCLES = 2800
) (
   input wire logic REF_CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe_n,
   input wire logic BUSY_OUT,
   input wire logic STANDBY_OUT
);
   logic [31:0] busy_cnt;

   default clocking cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);

   // Length of the running program cycle, so its bound needs no long repetition
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESET_N_IN || !BUSY_OUT) begin
         busy_cnt <= 32'h0;
      end else begin
         busy_cnt <= busy_cnt + 32'h1;
      end
   end

   property p_sda_open_drain;
      dev_sda_o == 1'b0;
   endproperty
   a_sda_open_drain: assert property (p_sda_open_drain)
      else $error("slave drives SDA high");

   property p_reset_to_standby;
      $rose(RESET_N_IN) |-> !STANDBY_OUT ##[1:3] STANDBY_OUT;
   endproperty
   a_reset_to_standby: assert property (p_reset_to_standby)
      else $error("no standby after reset release");

   property p_busy_quiet;
      BUSY_OUT |-> dev_sda_oe_n;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("slave drives SDA while programming");

   property p_busy_len;
      busy_cnt <= 32'(WRITE_CYCLES);
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("program cycle too long");

   property p_busy_not_standby;
      BUSY_OUT [*2] |-> !STANDBY_OUT;
   endproperty
   a_busy_not_standby: assert property (p_busy_not_standby)
      else $error("standby while programming");

   property p_busy_after_stop;
      $rose(BUSY_OUT) |-> scl && sda;
   endproperty
   a_busy_after_stop: assert property (p_busy_after_stop)
      else $error("program cycle began without stop");

   property p_sda_moves_scl_low;
      $changed(dev_sda_oe_n) |-> !scl;
   endproperty
   a_sda_moves_scl_low: assert property (p_sda_moves_scl_low)
      else $error("slave moved SDA while SCL high");

   property p_start_quiet;
      scl && $past(scl) && $fell(sda) |-> dev_sda_oe_n [*8];
   endproperty
   a_start_quiet: assert property (p_start_quiet)
      else $error("slave drives SDA right after start");

   property p_scl_high_min;
      $rose(scl) |-> scl [*8];
   endproperty
   a_scl_high_min: assert property (p_scl_high_min)
      else $error("SCL high phase too short");

   property p_scl_low_min;
      $fell(scl) |-> !scl [*8];
   endproperty
   a_scl_low_min: assert property (p_scl_low_min)
      else $error("SCL low phase too short");
endmodule

/* File: testbench/two_wire_eeprom_slave_port_tb.sv */
// Purpose: Self-checking bench joining the master and the EEPROM port
// Assumes: Select pins tied so the port answers with upper bits 1010 1 0
// Notes:   Program time shortened so polling still meets a busy device
`timescale 1ns/1ps
module two_wire_eeprom_slave_port_tb;
   localparam int WC = 2800;
   localparam int LIMIT = 4000;

   typedef struct packed {
      eeprom_pkg::host_cmd_t cmd;
      logic [7:0]            tx;
      logic                  ack_send;
      logic                  exp_ack;
      logic [7:0]            exp_rx;
   } row_t;

   logic                  ref_clk = 1'b0;
   logic                  reset_n = 1'b0;
   logic                  cmd_valid = 1'b0;
   eeprom_pkg::host_cmd_t cmd = eeprom_pkg::HCMD_START;
   logic [7:0]            tx_byte = 8'h00;
   logic                  ack_send = 1'b0;
   logic                  cs0 = 1'b0;
   logic                  cs1 = 1'b0;
   logic                  cs2 = 1'b1;
   logic                  wp = 1'b0;
   logic                  ready, done, ack_seen, busy, standby;
   logic [7:0]            rx_byte;
   int                    miscompares = 0;
   int                    n_tests = 0;
   int                    busy_run = 0;
   int                    busy_last = 0;
   int                    k;

   // Page write of three bytes wrapping at 0x10F, then reads back
   row_t rows [21] = '{
      '{eeprom_pkg::HCMD_START, 8'h00, 1'b0, 1'b0, 8'h00},
      '{eeprom_pkg::HCMD_WRITE, 8'hAA, 1'b0, 1'b1, 8'h00},
      '{eeprom_pkg::HCMD_WRITE, 8'h0E, 1'b0, 1'b1, 8'h00},
      '{eeprom_pkg::HCMD_WRITE, 8'h11, 1'b0, 1'b1, 8'h00},
      '{eeprom_pkg::HCMD_WRITE, 8'h22, 1'b0, 1'b1, 8'h00},
      '{eeprom_pkg::HCMD_WRITE, 8'h33, 1'b0, 1'b1, 8'h00},
      '{eeprom_pkg::HCMD_STOP,  8'h00, 1'b0, 1'b0, 8'h00},
      '{eeprom_pkg::HCMD_START, 8'h00, 1'b0, 1'b0, 8'h00},
      '{eeprom_pkg::HCMD_WRITE, 8'hAA, 1'b0, 1'b1, 8'h00},
      '{eeprom_pkg::HCMD_WRITE, 8'h0E, 1'b0, 1'b1, 8'h00},
      '{eeprom_pkg::HCMD_START, 8'h00, 1'b0, 1'b0, 8'h00},
      '{eeprom_pkg::HCMD_WRITE, 8'hAB, 1'b0, 1'b1, 8'h00},
      '{eeprom_pkg::HCMD_READ,  8'h00, 1'b0, 1'b0, 8'h11},
      '{eeprom_pkg::HCMD_READ,  8'h00, 1'b1, 1'b0, 8'h22},
      '{eeprom_pkg::HCMD_STOP,  8'h00, 1'b0, 1'b0, 8'h00},
      '{eeprom_pkg::HCMD_START, 8'h00, 1'b0, 1'b0, 8'h00},
      '{eeprom_pkg::HCMD_WRITE, 8'hAA, 1'b0, 1'b1, 8'h00},
      '{eeprom_pkg::HCMD_WRITE, 8'h00, 1'b0, 1'b1, 8'h00},
      '{eeprom_pkg::HCMD_START, 8'h00, 1'b0, 1'b0, 8'h00},
      '{eeprom_pkg::HCMD_WRITE, 8'hAB, 1'b0, 1'b1, 8'h00},
      '{eeprom_pkg::HCMD_READ,  8'h00, 1'b1, 1'b0, 8'h33}
   };

   two_wire_if two_wire_if_i ();

   two_wire_master two_wire_master_i (
      .REF_CLK_IN   (ref_clk),
      .RESET_N_IN   (reset_n),
      .bus          (two_wire_if_i.host),
      .CMD_VALID_IN (cmd_valid),
      .CMD_IN       (cmd),
      .TX_BYTE_IN   (tx_byte),
      .ACK_SEND_IN  (ack_send),
      .READY_OUT    (ready),
      .DONE_OUT     (done),
      .RX_BYTE_OUT  (rx_byte),
      .ACK_SEEN_OUT (ack_seen)
   );

   two_wire_eeprom_slave_port #(.WRITE_CYCLES(WC)) two_wire_eeprom_slave_port_i (
      .REF_CLK_IN                 (ref_clk),
      .RESET_N_IN                 (reset_n),
      .bus                        (two_wire_if_i.device),
      .CHIP_SELECT_BIT0_UNUSED_IN (cs0),
      .CHIP_SELECT_BIT1_IN        (cs1),
      .CHIP_SELECT_BIT2_IN        (cs2),
      .WRITE_PROTECT_IN           (wp),
      .BUSY_OUT                   (busy),
      .STANDBY_OUT                (standby)
   );

   two_wire_eeprom_slave_port_asserts #(.WRITE_CYCLES(WC)) two_wire_eeprom_slave_port_asserts_i (
      .REF_CLK_IN   (ref_clk),
      .RESET_N_IN   (reset_n),
      .scl          (two_wire_if_i.scl),
      .sda          (two_wire_if_i.sda),
      .dev_sda_o    (two_wire_if_i.dev_sda_o),
      .dev_sda_oe_n (two_wire_if_i.dev_sda_oe_n),
      .BUSY_OUT     (busy),
      .STANDBY_OUT  (standby)
   );

   always #2 ref_clk = ~ref_clk;

   // Length of the last program cycle
   always @(posedge ref_clk) begin
      if (busy === 1'b1) begin
         busy_run <= busy_run + 1;
      end else if (busy_run != 0) begin
         busy_last <= busy_run;
         busy_run <= 0;
      end
   end

   task automatic final_report;
      if (miscompares == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Valid is held one cycle only; a busy master would drop it anyway
   task automatic do_cmd(input eeprom_pkg::host_cmd_t c, input logic [7:0] b, input logic a);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < LIMIT) begin
         @(negedge ref_clk);
         n++;
      end
      cmd = c;
      tx_byte = b;
      ack_send = a;
      cmd_valid = 1'b1;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      while (done !== 1'b1 && n < LIMIT) begin
         @(negedge ref_clk);
         n++;
      end
      check("done", 8'h01, {7'h00, n < LIMIT});
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      repeat (20) @(negedge ref_clk);
      while (standby !== 1'b1 && n < WC + 500) begin
         @(negedge ref_clk);
         n++;
      end
      check("standby", 8'h01, {7'h00, standby});
   endtask

   task automatic sa;
      do_cmd(eeprom_pkg::HCMD_START, 8'h00, 1'b0);
   endtask

   task automatic so;
      do_cmd(eeprom_pkg::HCMD_STOP, 8'h00, 1'b0);
      wait_idle();
   endtask

   task automatic wr(input logic [7:0] b, input logic e);
      do_cmd(eeprom_pkg::HCMD_WRITE, b, 1'b0);
      check("ack", {7'h00, e}, {7'h00, ack_seen});
   endtask

   task automatic step(input row_t r);
      case (r.cmd)
         eeprom_pkg::HCMD_START: sa();
         eeprom_pkg::HCMD_STOP:  so();
         eeprom_pkg::HCMD_WRITE: wr(r.tx, r.exp_ack);
         default: begin
            do_cmd(r.cmd, r.tx, r.ack_send);
            check("rx", r.exp_rx, rx_byte);
         end
      endcase
   endtask

   // Hang guard sized well above the expected run
   initial begin
      repeat (95000) @(posedge ref_clk);
      miscompares++;
      final_report();
   end

   initial begin
      repeat (4) @(negedge ref_clk);
      reset_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      check("standby", 8'h01, {7'h00, standby});
      for (k = 0; k < 21; k++) step(rows[k]);
      so();
      // Upper select pair decides the match; the low pin is ignored
      cs0 = 1'b1;
      for (k = 0; k < 4; k++) begin
         sa();
         wr(8'hA0 | 8'(k << 2), k == 2);
         so();
      end
      // Protected data byte is refused and not stored
      wp = 1'b1;
      sa();
      wr(8'hAA, 1'b1);
      wr(8'h00, 1'b1);
      wr(8'h5A, 1'b0);
      so();
      wp = 1'b0;
      // Polling during the program cycle gets no answer
      sa();
      wr(8'hAA, 1'b1);
      wr(8'h01, 1'b1);
      wr(8'h77, 1'b1);
      do_cmd(eeprom_pkg::HCMD_STOP, 8'h00, 1'b0);
      sa();
      wr(8'hAA, 1'b0);
      so();
      check("busy_len", 8'h01, {7'h00, busy_last > WC / 2 && busy_last <= WC});
      // Protected byte kept, one-byte page write landed beside it
      sa();
      wr(8'hAA, 1'b1);
      wr(8'h00, 1'b1);
      sa();
      wr(8'hAB, 1'b1);
      do_cmd(eeprom_pkg::HCMD_READ, 8'h00, 1'b0);
      check("rx", 8'h33, rx_byte);
      do_cmd(eeprom_pkg::HCMD_READ, 8'h00, 1'b1);
      check("rx", 8'h77, rx_byte);
      so();
      // Reset in mid-transfer, then the port must work again
      sa();
      reset_n = 1'b0;
      repeat (4) @(negedge ref_clk);
      reset_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      check("standby", 8'h01, {7'h00, standby});
      sa();
      wr(8'hAA, 1'b1);
      so();
      final_report();
   end
endmodule
